// [hw/phyint_defines.svh]
// Offsets, field positions, reset values and encodings of the PHY interrupt block
`ifndef PHYINT_DEFINES_SVH
`define PHYINT_DEFINES_SVH

// ----------------------------------------------------------------------
// Register port geometry
// ----------------------------------------------------------------------
`define PHYINT_ADDR_W       5
`define PHYINT_REG_W        16
`define PHYINT_FLAG_OFS     5'h1d
`define PHYINT_ENABLE_OFS   5'h1e
`define PHYINT_STATUS_OFS   5'h1f

// ----------------------------------------------------------------------
// Event flag and enable positions
// ----------------------------------------------------------------------
`define PHYINT_B_TXOVF      10
`define PHYINT_B_TXUNF      9
`define PHYINT_B_IDLEOVF    8
`define PHYINT_B_ENERGY     7
`define PHYINT_B_NEGDONE    6
`define PHYINT_B_RFAULT     5
`define PHYINT_B_LINKDOWN   4
`define PHYINT_B_PACK       3
`define PHYINT_B_DFAULT     2
`define PHYINT_B_PAGE       1
`define PHYINT_B_LO         1
`define PHYINT_B_HI         10
`define PHYINT_FLAG_MASK    16'h07fe
`define PHYINT_FLAG_RST     16'h0000
`define PHYINT_ENABLE_RST   16'h0000
`define PHYINT_ZERO_WORD    16'h0000

// ----------------------------------------------------------------------
// Special status fields and speed encodings
// ----------------------------------------------------------------------
`define PHYINT_B_ANDONE     12
`define PHYINT_SPD_LSB      2
`define PHYINT_SPD_MSB      4
`define PHYINT_SPD_W        3
`define PHYINT_SPD_10HD     3'h1
`define PHYINT_SPD_10FD     3'h5
`define PHYINT_SPD_100HD    3'h2
`define PHYINT_SPD_100FD    3'h6

// ----------------------------------------------------------------------
// Input synchroniser layout
// ----------------------------------------------------------------------
`define PHYINT_SYNC_W       14
`define PHYINT_S_MSFAULT    0
`define PHYINT_S_SPD_LSB    11
`define PHYINT_S_SPD_MSB    13
`define PHYINT_SYNC_RST     14'h0000

`endif

// [hw/phyint_pkg.sv]
// Types shared by the PHY interrupt block
`include "phyint_defines.svh"

package phyint_pkg;

    // Register select decoded from the port address
    typedef enum logic [1:0] {
        PHYINT_SEL_NONE   = 2'b00,
        PHYINT_SEL_FLAG   = 2'b01,
        PHYINT_SEL_ENABLE = 2'b10,
        PHYINT_SEL_STATUS = 2'b11
    } phyint_sel_t;

    typedef struct packed {
        logic [`PHYINT_SYNC_W-1:0] stage1;
        logic [`PHYINT_SYNC_W-1:0] stage2;
    } phyint_sync_t;

    typedef struct packed {
        logic [`PHYINT_REG_W-1:0] flags;
    } phyint_flags_t;

    typedef struct packed {
        logic [`PHYINT_SYNC_W-1:0] prev;
        logic [`PHYINT_REG_W-1:0]  enable;
        logic [`PHYINT_REG_W-1:0]  rdata;
        logic                      rvalid;
        logic                      irq;
    } phyint_top_t;

endpackage

// [hw/phyint_sync.sv]
// Two-stage synchroniser for the event and status inputs
`timescale 1ns/1ps
`include "phyint_defines.svh"

module phyint_sync
    import phyint_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [`PHYINT_SYNC_W-1:0] async_i,
    output logic      [`PHYINT_SYNC_W-1:0] sync_o
);

    phyint_sync_t q;
    phyint_sync_t d;

    // First stage feeds only the second stage
    always_comb
    begin
        d        = q;
        d.stage1 = async_i;
        d.stage2 = q.stage1;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            q <= {`PHYINT_SYNC_RST, `PHYINT_SYNC_RST};
        end
        else
        begin
            q <= d;
        end
    end

    assign sync_o = q.stage2;

endmodule

// [hw/phyint_flag_bank.sv]
// Latched event flags with write-one-to-clear, set winning over clear
`timescale 1ns/1ps
`include "phyint_defines.svh"

module phyint_flag_bank
    import phyint_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    // Set and clear requests
    input  wire logic [`PHYINT_REG_W-1:0] set_i,
    input  wire logic [`PHYINT_REG_W-1:0] clr_i,
    // Latched flags
    output logic      [`PHYINT_REG_W-1:0] flags_o
);

    phyint_flags_t q;
    phyint_flags_t d;

    // An event in the clearing cycle survives the clear
    always_comb
    begin
        d       = q;
        d.flags = ((q.flags & ~clr_i) | set_i) & `PHYINT_FLAG_MASK;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            q <= `PHYINT_FLAG_RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign flags_o = q.flags;

endmodule

// [hw/phyint_top.sv]
// Event flags, event enables and special link status of the PHY management set
// Notes on behaviour
// - Bit 10 latches on transmit buffer overflow, bit 9 on underflow.
// - Flags latch high on event, hold until a write clears, reset low.
// - Bit 8 latches when the idle error count overflows.
// - Bit 7 latches on a rising edge of the energy present status.
// - Bit 6 latches when auto-negotiation completes.
// - Bit 5 latches when a remote fault is detected.
// - Bit 4 latches when link status falls, the link going down.
// - Bit 3 latches when the link partner acknowledges.
// - Bit 2 latches on parallel detection or master/slave configuration fault.
// - Bit 1 latches when a negotiation page has been received.
// - Enable bits 10 to 1 are read/write, one per flag position.
// - Enable zero masks its source, one enables it; reset to zero.
// - Status bit 12 is one only while auto-negotiation is done.
// - Done bit mirrors the basic status done bit; reads clear nothing.
// - Status bits 4:2 carry the resolved speed and duplex code.
// - Speed field follows the negotiation outcome, no fixed reset value.
`timescale 1ns/1ps
`include "phyint_defines.svh"

module phyint_top
    import phyint_pkg::*;
(
    // Clock and reset
    input  wire logic                      CLK_SYS_I,
    input  wire logic                      RST_N_I,
    // Register port, same clock domain
    input  wire logic [`PHYINT_ADDR_W-1:0] REG_ADDR_I,
    input  wire logic                      REG_WR_I,
    input  wire logic                      REG_RD_I,
    input  wire logic [`PHYINT_REG_W-1:0]  REG_WDATA_I,
    output logic      [`PHYINT_REG_W-1:0]  REG_RDATA_O,
    output logic                           REG_RVALID_O,
    // Event sources from the PHY core, asynchronous levels
    input  wire logic                      TX_BUFFER_OVERFLOW_I,
    input  wire logic                      TX_BUFFER_UNDERFLOW_I,
    input  wire logic                      IDLE_ERROR_OVERFLOW_I,
    input  wire logic                      ENERGY_PRESENT_STATUS_I,
    input  wire logic                      NEGOTIATION_DONE_I,
    input  wire logic                      REMOTE_FAULT_I,
    input  wire logic                      LINK_STATUS_I,
    input  wire logic                      PARTNER_ACK_I,
    input  wire logic                      PARALLEL_DETECT_FAULT_I,
    input  wire logic                      MASTER_SLAVE_FAULT_I,
    input  wire logic                      PAGE_RECEIVED_I,
    // Resolved link from auto-negotiation
    input  wire logic [`PHYINT_SPD_W-1:0]  RESOLVED_SPEED_DUPLEX_I,
    // Interrupt indication
    output logic                           IRQ_O
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic phyint_sel_t decode_sel(input logic [`PHYINT_ADDR_W-1:0] addr);
        phyint_sel_t sel;
        case (addr)
            `PHYINT_FLAG_OFS:   sel = PHYINT_SEL_FLAG;
            `PHYINT_ENABLE_OFS: sel = PHYINT_SEL_ENABLE;
            `PHYINT_STATUS_OFS: sel = PHYINT_SEL_STATUS;
            default:            sel = PHYINT_SEL_NONE;
        endcase
        return sel;
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    phyint_top_t               q;
    phyint_top_t               d;
    logic [`PHYINT_SYNC_W-1:0] raw_in;
    logic [`PHYINT_SYNC_W-1:0] sync_in;
    logic [`PHYINT_SYNC_W-1:0] rise;
    logic [`PHYINT_SYNC_W-1:0] fall;
    logic [`PHYINT_REG_W-1:0]  set_vec;
    logic [`PHYINT_REG_W-1:0]  clr_vec;
    logic [`PHYINT_REG_W-1:0]  flags;
    logic [`PHYINT_REG_W-1:0]  status_word;
    phyint_sel_t               wr_sel;
    phyint_sel_t               rd_sel;

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    // Each source sits at its flag position so one loop forms the events;
    // position 0 is free in the flag map and carries the second fault input.
    always_comb
    begin
        raw_in                                           = `PHYINT_SYNC_RST;
        raw_in[`PHYINT_S_MSFAULT]                        = MASTER_SLAVE_FAULT_I;
        raw_in[`PHYINT_B_PAGE]                           = PAGE_RECEIVED_I;
        raw_in[`PHYINT_B_DFAULT]                         = PARALLEL_DETECT_FAULT_I;
        raw_in[`PHYINT_B_PACK]                           = PARTNER_ACK_I;
        raw_in[`PHYINT_B_LINKDOWN]                       = LINK_STATUS_I;
        raw_in[`PHYINT_B_RFAULT]                         = REMOTE_FAULT_I;
        raw_in[`PHYINT_B_NEGDONE]                        = NEGOTIATION_DONE_I;
        raw_in[`PHYINT_B_ENERGY]                         = ENERGY_PRESENT_STATUS_I;
        raw_in[`PHYINT_B_IDLEOVF]                        = IDLE_ERROR_OVERFLOW_I;
        raw_in[`PHYINT_B_TXUNF]                          = TX_BUFFER_UNDERFLOW_I;
        raw_in[`PHYINT_B_TXOVF]                          = TX_BUFFER_OVERFLOW_I;
        raw_in[`PHYINT_S_SPD_MSB:`PHYINT_S_SPD_LSB]      = RESOLVED_SPEED_DUPLEX_I;
    end

    phyint_sync u_sync
    (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RST_N_I),
        .async_i (raw_in),
        .sync_o  (sync_in)
    );

    // ------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------
    // Edges are taken on the synchronised copy only, against the last sample
    genvar gi;
    generate
        for (gi = 0; gi < `PHYINT_SYNC_W; gi = gi + 1)
        begin : g_edge
            assign rise[gi] = sync_in[gi] & ~q.prev[gi];
            assign fall[gi] = ~sync_in[gi] & q.prev[gi];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Flag set vector
    // ------------------------------------------------------------------
    generate
        for (gi = `PHYINT_B_LO; gi <= `PHYINT_B_HI; gi = gi + 1)
        begin : g_set
            if (gi == `PHYINT_B_LINKDOWN)
            begin : g_down
                assign set_vec[gi] = fall[gi];
            end
            else if (gi == `PHYINT_B_DFAULT)
            begin : g_fault
                assign set_vec[gi] = rise[gi] | rise[`PHYINT_S_MSFAULT];
            end
            else
            begin : g_rise
                // Overflow, underflow, idle error, energy, done, fault, ack, page
                assign set_vec[gi] = rise[gi];
            end
        end
    endgenerate

    assign set_vec[0]                                     = 1'b0;
    assign set_vec[`PHYINT_REG_W-1:`PHYINT_B_HI+1]        = '0;

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    assign wr_sel  = decode_sel(REG_ADDR_I);
    assign rd_sel  = decode_sel(REG_ADDR_I);

    // Writing ones clears the matching flags; reserved bits are never stored
    assign clr_vec = (REG_WR_I && wr_sel == PHYINT_SEL_FLAG) ?
                     (REG_WDATA_I & `PHYINT_FLAG_MASK) : `PHYINT_ZERO_WORD;

    phyint_flag_bank u_flags
    (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RST_N_I),
        .set_i   (set_vec),
        .clr_i   (clr_vec),
        .flags_o (flags)
    );

    // ------------------------------------------------------------------
    // Special status word
    // ------------------------------------------------------------------
    // The speed field is live from the resolver, so it holds no value of its own
    always_comb
    begin
        status_word                                   = `PHYINT_ZERO_WORD;
        status_word[`PHYINT_B_ANDONE]                 = sync_in[`PHYINT_B_NEGDONE];
        status_word[`PHYINT_SPD_MSB:`PHYINT_SPD_LSB]  =
            sync_in[`PHYINT_S_SPD_MSB:`PHYINT_S_SPD_LSB];
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        d        = q;
        d.prev   = sync_in;
        d.rvalid = REG_RD_I;

        if (REG_WR_I && wr_sel == PHYINT_SEL_ENABLE)
        begin
            d.enable = REG_WDATA_I & `PHYINT_FLAG_MASK;
        end

        // Reads have no side effect, so status polling never loses an event
        if (REG_RD_I)
        begin
            case (rd_sel)
                PHYINT_SEL_FLAG:   d.rdata = flags;
                PHYINT_SEL_ENABLE: d.rdata = q.enable;
                PHYINT_SEL_STATUS: d.rdata = status_word;
                PHYINT_SEL_NONE:   d.rdata = `PHYINT_ZERO_WORD;
                default:           d.rdata = `PHYINT_ZERO_WORD;
            endcase
        end

        // One cycle behind the flags, traded for a glitch-free output
        d.irq = |(flags & q.enable);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            q.prev   <= `PHYINT_SYNC_RST;
            q.enable <= `PHYINT_ENABLE_RST;
            q.rdata  <= `PHYINT_ZERO_WORD;
            q.rvalid <= 1'b0;
            q.irq    <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign REG_RDATA_O  = q.rdata;
    assign REG_RVALID_O = q.rvalid;
    assign IRQ_O        = q.irq;

endmodule

// [verification/phyint_top_properties.sv]
// Port checks for the PHY interrupt block
`timescale 1ns/1ps
`include "phyint_defines.svh"

module phyint_top_properties
    import phyint_pkg::*;
(
    // Clock and reset
    input wire logic                      CLK_SYS_I,
    input wire logic                      RST_N_I,
    // Register port
    input wire logic [`PHYINT_ADDR_W-1:0] REG_ADDR_I,
    input wire logic                      REG_WR_I,
    input wire logic                      REG_RD_I,
    input wire logic [`PHYINT_REG_W-1:0]  REG_WDATA_I,
    input wire logic [`PHYINT_REG_W-1:0]  REG_RDATA_O,
    input wire logic                      REG_RVALID_O,
    // Status inputs and interrupt
    input wire logic                      NEGOTIATION_DONE_I,
    input wire logic [`PHYINT_SPD_W-1:0]  RESOLVED_SPEED_DUPLEX_I,
    input wire logic                      IRQ_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);

    read_valid_a:
        assert property (1'b1 |=> REG_RVALID_O == $past(REG_RD_I))
        else $error("Bad read valid");
    unmapped_zero_a:
        assert property (REG_RVALID_O && $past(REG_ADDR_I) < `PHYINT_FLAG_OFS
            |-> REG_RDATA_O == 16'h0000)
        else $error("Unmapped read not zero");
    flag_reserved_a:
        assert property (REG_RVALID_O
            && $past(REG_ADDR_I) inside {`PHYINT_FLAG_OFS, `PHYINT_ENABLE_OFS}
            |-> (REG_RDATA_O & ~`PHYINT_FLAG_MASK) == 16'h0000)
        else $error("Reserved flag bits set");
    status_reserved_a:
        assert property (REG_RVALID_O && $past(REG_ADDR_I) == `PHYINT_STATUS_OFS
            |-> (REG_RDATA_O & 16'hefe3) == 16'h0000)
        else $error("Reserved status bits set");
    rdata_hold_a:
        assert property (!REG_RVALID_O |-> $stable(REG_RDATA_O))
        else $error("Read data moved");
    enable_readback_a:
        assert property (REG_WR_I && REG_ADDR_I == `PHYINT_ENABLE_OFS ##1 !REG_WR_I
            ##1 REG_RD_I && !REG_WR_I && REG_ADDR_I == `PHYINT_ENABLE_OFS
            |=> REG_RDATA_O == ($past(REG_WDATA_I, 3) & `PHYINT_FLAG_MASK))
        else $error("Enable readback wrong");
    irq_masked_a:
        assert property (REG_WR_I && REG_ADDR_I == `PHYINT_ENABLE_OFS
            && (REG_WDATA_I & `PHYINT_FLAG_MASK) == 16'h0000 ##1 !REG_WR_I |=> !IRQ_O)
        else $error("IRQ not masked");
    // The read data carries the input as sampled three edges before it is shown
    done_mirror_a:
        assert property (REG_RVALID_O && $past(REG_ADDR_I) == `PHYINT_STATUS_OFS
            && $past(NEGOTIATION_DONE_I, 3) == NEGOTIATION_DONE_I
            |-> REG_RDATA_O[`PHYINT_B_ANDONE] == NEGOTIATION_DONE_I)
        else $error("Bad done bit");
    speed_mirror_a:
        assert property (REG_RVALID_O && $past(REG_ADDR_I) == `PHYINT_STATUS_OFS
            && $past(RESOLVED_SPEED_DUPLEX_I, 3) == RESOLVED_SPEED_DUPLEX_I
            |-> REG_RDATA_O[`PHYINT_SPD_MSB:`PHYINT_SPD_LSB] == RESOLVED_SPEED_DUPLEX_I)
        else $error("Bad speed");
endmodule

bind phyint_top phyint_top_properties i_phyint_top_properties (
    .CLK_SYS_I, .RST_N_I, .REG_ADDR_I, .REG_WR_I, .REG_RD_I, .REG_WDATA_I, .REG_RDATA_O,
    .REG_RVALID_O, .NEGOTIATION_DONE_I, .RESOLVED_SPEED_DUPLEX_I, .IRQ_O
);

// [verification/phyint_mgmt_model.sv]
// Management-side register master model for the PHY interrupt block
`timescale 1ns/1ps
`include "phyint_defines.svh"

module phyint_mgmt_model
    import phyint_pkg::*;
(
    // Clock
    input  wire logic                      clk_i,
    // Register port towards the block
    output logic      [`PHYINT_ADDR_W-1:0] addr_o,
    output logic                           wr_o,
    output logic                           rd_o,
    output logic      [`PHYINT_REG_W-1:0]  wdata_o,
    input  wire logic [`PHYINT_REG_W-1:0]  rdata_i,
    input  wire logic                      rvalid_i
);
    initial
    begin
        addr_o  = 5'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        wdata_o = 16'h0000;
    end

    // Released lines show the inverse so a stale value cannot pass for a live one
    task automatic wr_reg(input logic [`PHYINT_ADDR_W-1:0] a, input logic [`PHYINT_REG_W-1:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask

    // Answer comes exactly one cycle after the read edge
    task automatic rd_reg(input logic [`PHYINT_ADDR_W-1:0] a, output logic [`PHYINT_REG_W-1:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
        @(posedge clk_i);
        d = (rvalid_i === 1'b1) ? rdata_i : 16'hxxxx;
    endtask
endmodule

// [verification/phyint_top_test.sv]
// Self-checking bench for the PHY interrupt block
`timescale 1ns/1ps
`include "phyint_defines.svh"

module phyint_top_test
    import phyint_pkg::*;
;
    localparam logic [10:0] EV_IDLE    = 11'h040;
    localparam logic [4:0]  FLAG_OFS   = `PHYINT_FLAG_OFS;
    localparam logic [4:0]  STATUS_OFS = `PHYINT_STATUS_OFS;

    logic                      clk_sys;
    logic                      rst_n;
    logic [`PHYINT_ADDR_W-1:0] reg_addr;
    logic                      reg_wr;
    logic                      reg_rd;
    logic [`PHYINT_REG_W-1:0]  reg_wdata;
    logic [`PHYINT_REG_W-1:0]  reg_rdata;
    logic                      reg_rvalid;
    logic                      irq;
    logic [10:0]               ev;
    logic [`PHYINT_SPD_W-1:0]  speed;
    int                        fail_count;
    int                        compares;
    int                        cycles;
    logic [15:0]               pos_word;
    // Flag position per event input; both fault inputs share one position
    int                        flag_pos [11] = '{10, 9, 8, 7, 6, 5, 4, 3, 2, 2, 1};
    logic [2:0]                spd_code [4] = '{`PHYINT_SPD_10HD, `PHYINT_SPD_10FD,
                                                `PHYINT_SPD_100HD, `PHYINT_SPD_100FD};

    phyint_top i_phyint_top (
        .CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .REG_ADDR_I(reg_addr), .REG_WR_I(reg_wr),
        .REG_RD_I(reg_rd), .REG_WDATA_I(reg_wdata), .REG_RDATA_O(reg_rdata),
        .REG_RVALID_O(reg_rvalid),
        .TX_BUFFER_OVERFLOW_I(ev[0]), .TX_BUFFER_UNDERFLOW_I(ev[1]), .IDLE_ERROR_OVERFLOW_I(ev[2]),
        .ENERGY_PRESENT_STATUS_I(ev[3]), .NEGOTIATION_DONE_I(ev[4]), .REMOTE_FAULT_I(ev[5]),
        .LINK_STATUS_I(ev[6]), .PARTNER_ACK_I(ev[7]), .PARALLEL_DETECT_FAULT_I(ev[8]),
        .MASTER_SLAVE_FAULT_I(ev[9]), .PAGE_RECEIVED_I(ev[10]), .RESOLVED_SPEED_DUPLEX_I(speed),
        .IRQ_O(irq)
    );

    phyint_mgmt_model i_phyint_mgmt_model (
        .clk_i(clk_sys), .addr_o(reg_addr), .wr_o(reg_wr), .rd_o(reg_rd),
        .wdata_o(reg_wdata), .rdata_i(reg_rdata), .rvalid_i(reg_rvalid)
    );

    always #25 clk_sys = ~clk_sys;

    task automatic give_verdict();
        $display("Compares %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        i_phyint_mgmt_model.rd_reg(a, d);
        chk(d, exp);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        i_phyint_mgmt_model.wr_reg(a, d);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial
    begin
        clk_sys    = 1'b0;
        rst_n      = 1'b0;
        ev         = EV_IDLE;
        speed      = 3'h0;
        fail_count = 0;
        compares   = 0;
        cycles     = 0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(FLAG_OFS, `PHYINT_FLAG_RST);
        rd(`PHYINT_ENABLE_OFS, `PHYINT_ENABLE_RST);
        wr(5'h00, 16'hffff);
        rd(5'h00, 16'h0000);
        wr(STATUS_OFS, 16'hffff);
        rd(STATUS_OFS, 16'h0000);
        wr(`PHYINT_ENABLE_OFS, 16'hffff);
        rd(`PHYINT_ENABLE_OFS, `PHYINT_FLAG_MASK);
        // Each source in turn: latch, mask, hold through a zero write, enable, clear
        for (int i = 0; i < 11; i++)
        begin
            pos_word = 16'(1 << flag_pos[i]);
            wr(`PHYINT_ENABLE_OFS, 16'h0000);
            ev[i] <= ~EV_IDLE[i];
            repeat (4) @(posedge clk_sys);
            ev[i] <= EV_IDLE[i];
            repeat (4) @(posedge clk_sys);
            rd(FLAG_OFS, pos_word);
            chk({15'h0000, irq}, 16'h0000);
            wr(FLAG_OFS, 16'h0000);
            wr(`PHYINT_ENABLE_OFS, pos_word);
            repeat (3) @(posedge clk_sys);
            chk({15'h0000, irq}, 16'h0001);
            wr(FLAG_OFS, pos_word);
            repeat (3) @(posedge clk_sys);
            chk({15'h0000, irq}, 16'h0000);
            rd(FLAG_OFS, 16'h0000);
            // Only the leading edge sets a flag; the return edge after a clear stays quiet
            ev[i] <= ~EV_IDLE[i];
            repeat (4) @(posedge clk_sys);
            wr(FLAG_OFS, pos_word);
            ev[i] <= EV_IDLE[i];
            repeat (4) @(posedge clk_sys);
            rd(FLAG_OFS, 16'h0000);
        end
        // Speed codes with negotiation done; status reads leave the flags alone
        ev[4] <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            speed <= spd_code[k];
            repeat (4) @(posedge clk_sys);
            rd(STATUS_OFS, 16'h1000 | 16'({spd_code[k], 2'b00}));
        end
        rd(FLAG_OFS, 16'h0040);
        ev[4] <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd(STATUS_OFS, 16'h0018);
        // Reset in mid-run drops flags and enables
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(FLAG_OFS, 16'h0000);
        rd(`PHYINT_ENABLE_OFS, 16'h0000);
        give_verdict();
    end
endmodule
